//--- include/gafm_pkg.sv
package gafm_pkg;
	localparam int          NUM_PINS      = 54;
	localparam int          LOW_PINS      = 32;
	localparam int          HIGH_PINS     = 22;
	localparam int          SEL_PINS      = 16;
	localparam int          ADDR_W        = 12;
	localparam int          DATA_W        = 32;
	localparam int          STRB_W        = 4;
	localparam int          SYNC_DEPTH    = 3;
	// register byte offsets
	localparam logic [11:0] PIN_FUNCTION_LOW_OFF  = 12'ha90;
	localparam logic [11:0] PIN_FUNCTION_HIGH_OFF = 12'ha94;
	localparam logic [11:0] ALT_SELECT_LOW_OFF    = 12'ha98;
	// writable bit masks; masked bits read as zero
	localparam logic [31:0] PIN_FUNCTION_LOW_MASK  = 32'hffffffff;
	localparam logic [31:0] PIN_FUNCTION_HIGH_MASK = 32'h003fffff;
	localparam logic [31:0] ALT_SELECT_LOW_MASK    = 32'hffff0fff;
	localparam logic [31:0] REG_RESET              = 32'h00000000;
	// alternate function selector codes
	localparam logic [1:0]  SEL_FUNC_ZERO = 2'h0;
	localparam logic [1:0]  SEL_FUNC_ONE  = 2'h1;
	localparam logic [1:0]  SEL_W         = 2'h2;
	// axi responses
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		GAFM_WR_IDLE = 2'h1,
		GAFM_WR_RESP = 2'h2
	} gafm_wr_state_t;
	typedef enum logic [1:0] {
		GAFM_RD_IDLE = 2'h1,
		GAFM_RD_RESP = 2'h2
	} gafm_rd_state_t;
endpackage

//--- rtl/gafm_pin_cell.sv
`timescale 1ns/1ps
module gafm_pin_cell
(
	// clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       rst_n_i,
	// pin configuration
	input  wire logic       func_en_i,
	input  wire logic [1:0] alt_sel_i,
	// general purpose side
	input  wire logic       gpio_out_i,
	input  wire logic       gpio_dir_i,
	output logic            gpio_in_o,
	// alternate functions
	input  wire logic       af0_out_i,
	input  wire logic       af0_oe_i,
	input  wire logic       af1_out_i,
	input  wire logic       af1_oe_i,
	output logic            af0_in_o,
	output logic            af1_in_o,
	// pad
	input  wire logic       pad_i,
	output logic            pad_o,
	output logic            pad_oe_n_o
);
	import gafm_pkg::*;

	logic [SYNC_DEPTH-1:0] sync_r;
	logic                  in_r;
	logic                  drv_nxt;
	logic                  oe_nxt;

	always_comb begin
		drv_nxt = 1'b0;
		oe_nxt  = 1'b0;
		if (func_en_i) begin
			case (alt_sel_i)
				SEL_FUNC_ZERO: begin
					drv_nxt = af0_out_i;
					oe_nxt  = af0_oe_i;
				end
				SEL_FUNC_ONE: begin
					drv_nxt = af1_out_i;
					oe_nxt  = af1_oe_i;
				end
				// reserved codes leave the pin undriven
				default: begin
					drv_nxt = 1'b0;
					oe_nxt  = 1'b0;
				end
			endcase
		end else begin
			drv_nxt = gpio_out_i;
			oe_nxt  = gpio_dir_i;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pad_o      <= 1'b0;
			pad_oe_n_o <= 1'b1;
		end else begin
			pad_o      <= drv_nxt;
			pad_oe_n_o <= ~oe_nxt;
		end
	end

	// pad is asynchronous: accept a change only once stages two and three agree
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync_r <= '0;
			in_r   <= 1'b0;
		end else begin
			sync_r <= {sync_r[SYNC_DEPTH-2:0], pad_i};
			if (sync_r[1] == sync_r[2])
				in_r <= sync_r[2];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gpio_in_o <= 1'b0;
			af0_in_o  <= 1'b0;
			af1_in_o  <= 1'b0;
		end else begin
			gpio_in_o <= in_r;
			af0_in_o  <= in_r & func_en_i & (alt_sel_i == SEL_FUNC_ZERO);
			af1_in_o  <= in_r & func_en_i & (alt_sel_i == SEL_FUNC_ONE);
		end
	end
endmodule

//--- rtl/gafm_top.sv
// Functional notes
// - enable one: pin follows selected alternate function
// - enable zero: pin is plain general purpose
// - low enable register: bit n drives pin n
// - high enable bits 21:0 pins 32-53, rest zero
// - selector 0 first, 1 second, 2-3 none
// - selector bits 2n+1:2n, bits 15:12 read zero
// - gpio direction bit sets output only while enable is zero; with enable one the alternate decides
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
module gafm_top
(
	// clock and resets
	input  wire logic                        sys_clk_i,
	input  wire logic                        rst_n_i,
	input  wire logic                        soft_rst_n_i,
	// axi4-lite write address
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [gafm_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]                  s_axi_awprot,
	// axi4-lite write data
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	input  wire logic [gafm_pkg::DATA_W-1:0] s_axi_wdata,
	input  wire logic [gafm_pkg::STRB_W-1:0] s_axi_wstrb,
	// axi4-lite write response
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	output logic [1:0]                       s_axi_bresp,
	// axi4-lite read
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	input  wire logic [gafm_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]                  s_axi_arprot,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	output logic [gafm_pkg::DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	// general purpose side
	input  wire logic [gafm_pkg::NUM_PINS-1:0] gpio_out_i,
	input  wire logic [gafm_pkg::NUM_PINS-1:0] pin_direction_config_i,
	output logic [gafm_pkg::NUM_PINS-1:0]      gpio_in_o,
	// alternate functions
	input  wire logic [gafm_pkg::NUM_PINS-1:0] alternate_function_zero_out_i,
	input  wire logic [gafm_pkg::NUM_PINS-1:0] alternate_function_zero_oe_i,
	input  wire logic [gafm_pkg::NUM_PINS-1:0] alternate_function_one_out_i,
	input  wire logic [gafm_pkg::NUM_PINS-1:0] alternate_function_one_oe_i,
	output logic [gafm_pkg::NUM_PINS-1:0]      alternate_function_zero_in_o,
	output logic [gafm_pkg::NUM_PINS-1:0]      alternate_function_one_in_o,
	// pads
	input  wire logic [gafm_pkg::NUM_PINS-1:0] pad_i,
	output logic [gafm_pkg::NUM_PINS-1:0]      pad_o,
	output logic [gafm_pkg::NUM_PINS-1:0]      pad_oe_n_o
);
	import gafm_pkg::*;

	logic [31:0]          pin_function_low_r;
	logic [31:0]          pin_function_high_r;
	logic [31:0]          alt_select_low_r;
	logic                 aw_held_r;
	logic                 w_held_r;
	logic [ADDR_W-1:0]    waddr_r;
	logic [DATA_W-1:0]    wdata_r;
	logic [STRB_W-1:0]    wstrb_r;
	gafm_wr_state_t       wr_state_r;
	gafm_rd_state_t       rd_state_r;
	logic                 do_write;
	logic [31:0]          bytemask;
	logic                 wr_hit;
	logic [31:0]          rd_val;
	logic                 rd_hit;
	logic [NUM_PINS-1:0]  func_en;
	logic [2*NUM_PINS-1:0] alt_sel;

	assign s_axi_awready = (wr_state_r == GAFM_WR_IDLE) && !aw_held_r;
	assign s_axi_wready  = (wr_state_r == GAFM_WR_IDLE) && !w_held_r;
	assign s_axi_arready = (rd_state_r == GAFM_RD_IDLE);
	assign s_axi_bvalid  = (wr_state_r == GAFM_WR_RESP);
	assign s_axi_rvalid  = (rd_state_r == GAFM_RD_RESP);
	assign do_write      = (wr_state_r == GAFM_WR_IDLE) && aw_held_r && w_held_r;

	always_comb begin
		for (int b = 0; b < STRB_W; b++)
			bytemask[8*b +: 8] = {8{wstrb_r[b]}};
	end

	always_comb begin
		case (waddr_r[ADDR_W-1:2])
			PIN_FUNCTION_LOW_OFF[11:2],
			PIN_FUNCTION_HIGH_OFF[11:2],
			ALT_SELECT_LOW_OFF[11:2]: wr_hit = 1'b1;
			default:                  wr_hit = 1'b0;
		endcase
	end

	// address and data may arrive in either order; each is held until both are in
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			waddr_r   <= '0;
			wdata_r   <= '0;
			wstrb_r   <= '0;
		end else if (!soft_rst_n_i) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				waddr_r   <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held_r <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end else if (do_write) begin
				w_held_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_state_r  <= GAFM_WR_IDLE;
			s_axi_bresp <= RESP_OKAY;
		end else if (!soft_rst_n_i) begin
			wr_state_r  <= GAFM_WR_IDLE;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			case (wr_state_r)
				GAFM_WR_IDLE: begin
					if (do_write) begin
						wr_state_r  <= GAFM_WR_RESP;
						s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
					end
				end
				GAFM_WR_RESP: begin
					if (s_axi_bready)
						wr_state_r <= GAFM_WR_IDLE;
				end
				default: wr_state_r <= GAFM_WR_IDLE;
			endcase
		end
	end

	// sticky fields: only the full reset clears them, the light reset leaves them
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_function_low_r  <= REG_RESET;
			pin_function_high_r <= REG_RESET;
			alt_select_low_r    <= REG_RESET;
		end else if (do_write) begin
			case (waddr_r[ADDR_W-1:2])
				PIN_FUNCTION_LOW_OFF[11:2]:
					pin_function_low_r <= (pin_function_low_r & ~bytemask)
						| (wdata_r & bytemask & PIN_FUNCTION_LOW_MASK);
				PIN_FUNCTION_HIGH_OFF[11:2]:
					pin_function_high_r <= (pin_function_high_r & ~bytemask)
						| (wdata_r & bytemask & PIN_FUNCTION_HIGH_MASK);
				ALT_SELECT_LOW_OFF[11:2]:
					alt_select_low_r <= (alt_select_low_r & ~bytemask)
						| (wdata_r & bytemask & ALT_SELECT_LOW_MASK);
				default: ;
			endcase
		end
	end

	always_comb begin
		rd_hit = 1'b1;
		case (s_axi_araddr[ADDR_W-1:2])
			PIN_FUNCTION_LOW_OFF[11:2]:  rd_val = pin_function_low_r;
			PIN_FUNCTION_HIGH_OFF[11:2]: rd_val = pin_function_high_r & PIN_FUNCTION_HIGH_MASK;
			ALT_SELECT_LOW_OFF[11:2]:    rd_val = alt_select_low_r & ALT_SELECT_LOW_MASK;
			default: begin
				rd_val = 32'h00000000;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_state_r  <= GAFM_RD_IDLE;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (!soft_rst_n_i) begin
			rd_state_r  <= GAFM_RD_IDLE;
		end else begin
			case (rd_state_r)
				GAFM_RD_IDLE: begin
					if (s_axi_arvalid) begin
						rd_state_r  <= GAFM_RD_RESP;
						s_axi_rdata <= rd_val;
						s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
					end
				end
				GAFM_RD_RESP: begin
					if (s_axi_rready)
						rd_state_r <= GAFM_RD_IDLE;
				end
				default: rd_state_r <= GAFM_RD_IDLE;
			endcase
		end
	end

	// pins without a selector in this block run alternate function zero
	always_comb begin
		func_en = {pin_function_high_r[HIGH_PINS-1:0], pin_function_low_r};
		alt_sel = '0;
		for (int p = 0; p < SEL_PINS; p++)
			alt_sel[2*p +: 2] = alt_select_low_r[2*p +: 2] & ALT_SELECT_LOW_MASK[2*p +: 2];
	end

	for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
		gafm_pin_cell u_cell (
			.sys_clk_i  (sys_clk_i),
			.rst_n_i    (rst_n_i),
			.func_en_i  (func_en[g]),
			.alt_sel_i  (alt_sel[2*g +: 2]),
			.gpio_out_i (gpio_out_i[g]),
			.gpio_dir_i (pin_direction_config_i[g]),
			.gpio_in_o  (gpio_in_o[g]),
			.af0_out_i  (alternate_function_zero_out_i[g]),
			.af0_oe_i   (alternate_function_zero_oe_i[g]),
			.af1_out_i  (alternate_function_one_out_i[g]),
			.af1_oe_i   (alternate_function_one_oe_i[g]),
			.af0_in_o   (alternate_function_zero_in_o[g]),
			.af1_in_o   (alternate_function_one_in_o[g]),
			.pad_i      (pad_i[g]),
			.pad_o      (pad_o[g]),
			.pad_oe_n_o (pad_oe_n_o[g])
		);
	end
endmodule

//--- testbench/gafm_monitor.sv
`timescale 1ns/1ps
module gafm_monitor
	import gafm_pkg::*;
(
	// clock and reset
	input wire logic			sys_clk_i,
	input wire logic			rst_n_i,
	// register bus
	input wire logic			s_axi_awvalid,
	input wire logic			s_axi_awready,
	input wire logic			s_axi_wvalid,
	input wire logic			s_axi_wready,
	input wire logic			s_axi_bvalid,
	input wire logic			s_axi_bready,
	input wire logic [1:0]			s_axi_bresp,
	input wire logic			s_axi_arvalid,
	input wire logic			s_axi_arready,
	input wire logic			s_axi_rvalid,
	input wire logic			s_axi_rready,
	input wire logic [DATA_W-1:0]		s_axi_rdata,
	input wire logic [1:0]			s_axi_rresp,
	// pins
	input wire logic [NUM_PINS-1:0]		pad_oe_n_o,
	input wire logic [NUM_PINS-1:0]		alternate_function_zero_in_o,
	input wire logic [NUM_PINS-1:0]		alternate_function_one_in_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// both halves taken at one edge: the register is written one edge later, the answer stands after that
	a_write_answer_time: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_read_answer_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	a_write_reopens: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
		else $error("write not reopened");
	a_unmapped_reads_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == '0)
		else $error("error read carries data");
	a_reset_pads_off: assert property (disable iff (1'b0) !rst_n_i |-> pad_oe_n_o == '1 && !s_axi_bvalid)
		else $error("pads driven in reset");
	a_one_function_only: assert property ((alternate_function_zero_in_o & alternate_function_one_in_o) == '0)
		else $error("both functions fed");
endmodule
bind gafm_top gafm_monitor u_mon (.sys_clk_i, .rst_n_i, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .s_axi_rdata, .s_axi_rresp, .pad_oe_n_o, .alternate_function_zero_in_o,
	.alternate_function_one_in_o);

//--- testbench/gafm_top_tb.sv
`timescale 1ns/1ps
module gafm_top_tb;
	import gafm_pkg::*;
	logic			sys_clk_i = 1'b0;
	logic			rst_n_i = 1'b1;
	logic			soft_rst_n_i = 1'b1;
	logic			awv = 1'b0, wv = 1'b0, arv = 1'b0, bre = 1'b0, rre = 1'b0;
	logic [11:0]		awa = 12'h0, ara = 12'h0;
	logic [31:0]		wd = 32'h0, rd;
	logic [NUM_PINS-1:0]	go = '0, dir = '0, a0o = '0, a0e = '0, a1o = '0, a1e = '0, pad = '0;
	logic			awr, wrdy, bv, arr, rv;
	logic [1:0]		br, rr;
	logic [NUM_PINS-1:0]	gin, a0i, a1i, pdo, poe;
	logic [33:0]		bus_q[$];
	logic [269:0]		pin_q[$], pe;
	logic [31:0]		v[4];
	logic [11:0]		adr[4] = '{PIN_FUNCTION_LOW_OFF, PIN_FUNCTION_HIGH_OFF, ALT_SELECT_LOW_OFF, 12'ha9c};
	logic [31:0]		msk[4] = '{PIN_FUNCTION_LOW_MASK, PIN_FUNCTION_HIGH_MASK, ALT_SELECT_LOW_MASK, 32'h0};
	logic [1:0]		rsp[4] = '{RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_SLVERR};
	int			err_total = 0, comparisons = 0, seed = 42;
	event			pin_ev;

	always #50 sys_clk_i = ~sys_clk_i;

	gafm_top uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .soft_rst_n_i(soft_rst_n_i),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
		.s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
		.s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_rvalid(rv), .s_axi_rready(rre), .s_axi_rdata(rd),
		.s_axi_rresp(rr), .gpio_out_i(go), .pin_direction_config_i(dir), .gpio_in_o(gin),
		.alternate_function_zero_out_i(a0o), .alternate_function_zero_oe_i(a0e),
		.alternate_function_one_out_i(a1o), .alternate_function_one_oe_i(a1e),
		.alternate_function_zero_in_o(a0i), .alternate_function_one_in_o(a1i),
		.pad_i(pad), .pad_o(pdo), .pad_oe_n_o(poe));

	task automatic chk_bus(input logic [33:0] g, input logic [33:0] e);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic chk_pin(input logic [269:0] g, input logic [269:0] e);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	function automatic logic [NUM_PINS-1:0] rnd;
		logic [63:0] x;
		x = {$random(seed), $random(seed)};
		return x[NUM_PINS-1:0];
	endfunction

	// one transfer; ready rises two edges in, so a read answer waits one cycle for hold rules while a write answer is taken at once
	task automatic bus(input bit w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
		logic [2:0] t;
		logic done;
		int n;
		bus_q.push_back(e);
		{awv, wv, arv} <= {w, w, !w};
		{awa, ara, wd, bre, rre} <= {a, a, d, 2'b00};
		n = 0;
		done = 1'b0;
		while (!done) begin
			@(negedge sys_clk_i);
			t = {awr && awv, wrdy && wv, arr && arv};
			done = (bv && bre) || (rv && rre);
			@(posedge sys_clk_i);
			n++;
			if (t[2]) awv <= 1'b0;
			if (t[1]) wv <= 1'b0;
			if (t[0]) arv <= 1'b0;
			if (n == 2) {bre, rre} <= 2'b11;
			if (n > 40) begin
				err_total++;
				test_done;
			end
		end
	endtask

	always @(negedge sys_clk_i) begin
		if (bv && bre) chk_bus({br, 32'h0}, bus_q.pop_front());
		if (rv && rre) chk_bus({rr, rd}, bus_q.pop_front());
	end

	task automatic pins(input logic [31:0] e0, input logic [31:0] e1, input logic [31:0] s);
		logic [NUM_PINS-1:0] en, oe, po, x0, x1;
		logic [1:0] c;
		{go, dir, a0o, a0e} <= {rnd(), rnd(), rnd(), rnd()};
		{a1o, a1e, pad} <= {rnd(), rnd(), rnd()};
		repeat (8) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		en = {e1[21:0], e0};
		for (int i = 0; i < NUM_PINS; i++) begin
			c = (i < SEL_PINS && i != 6 && i != 7) ? 2'(s >> (2 * i)) : SEL_FUNC_ZERO;
			oe[i] = en[i] ? (c == SEL_FUNC_ZERO ? ~a0e[i] : c == SEL_FUNC_ONE ? ~a1e[i] : 1'b1) : ~dir[i];
			po[i] = en[i] ? (c == SEL_FUNC_ZERO ? a0o[i] : a1o[i]) : go[i];
			x0[i] = en[i] && c == SEL_FUNC_ZERO && pad[i];
			x1[i] = en[i] && c == SEL_FUNC_ONE && pad[i];
		end
		pin_q.push_back({oe, po & ~oe, pad, x0, x1});
		-> pin_ev;
		@(posedge sys_clk_i);
	endtask

	always @(pin_ev) begin
		pe = pin_q.pop_front();
		chk_pin({poe, pdo & ~pe[269:216], gin, a0i, a1i}, pe);
	end

	initial begin
		// a real falling edge at time zero, so the asynchronous reset acts before the first clock edge
		rst_n_i <= 1'b0;
		repeat (12) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		foreach (v[i]) bus(0, adr[i], 32'h0, {rsp[i], REG_RESET});
		pins(32'h0, 32'h0, 32'h0);
		$display("reset values done");
		// first pass sets every selector code and the read-only selector bits
		for (int k = 0; k < 8; k++) begin
			foreach (v[i]) v[i] = k == 0 ? 32'he4e4_fee4 : $random(seed);
			foreach (v[i]) bus(1, adr[i], v[i], {rsp[i], 32'h0});
			foreach (v[i]) bus(0, adr[i], 32'h0, {rsp[i], v[i] & msk[i]});
			pins(v[0], v[1], v[2]);
		end
		$display("registers and pins done");
		soft_rst_n_i <= 1'b0;
		@(posedge sys_clk_i);
		soft_rst_n_i <= 1'b1;
		foreach (v[i]) bus(0, adr[i], 32'h0, {rsp[i], v[i] & msk[i]});
		pins(v[0], v[1], v[2]);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		foreach (v[i]) bus(0, adr[i], 32'h0, {rsp[i], REG_RESET});
		$display("resets done");
		test_done;
	end
endmodule
